// [rtl/astp_defs.svh]
// Offsets, field positions, reset values and timing counts of the transport packer.
`ifndef ASTP_DEFS_SVH
`define ASTP_DEFS_SVH
`define ASTP_ADDR_TPC 8'hC0
`define ASTP_ADDR_LANES 8'hC1
`define ASTP_ADDR_KFR 8'hC2
`define ASTP_ADDR_MODE 8'hC3
`define ASTP_ADDR_STAT 8'hC4
`define ASTP_TPC_EN_BIT 7
`define ASTP_TPC_SEL_MSB 2
`define ASTP_MODE_SIMPLE_BIT 0
`define ASTP_MODE_SCR_BIT 1
`define ASTP_TPC_RST 8'h00
`define ASTP_LANES_RST 8'h02
`define ASTP_KFR_RST 8'h08
`define ASTP_MODE_RST 8'h00
`define ASTP_LANES_M1_THREE 8'h02
`define ASTP_F_EFF_M1 3'h6
`define ASTP_F_SIMPLE_M1 3'h1
`define ASTP_GRP3_LAST 4'hB
`define ASTP_GRP2_LAST 4'h7
`define ASTP_K_MIN_EFF_M1 5'h02
`define ASTP_K_MIN_SIMPLE_M1 5'h08
`define ASTP_ILA_MF_LAST 2'h3
`define ASTP_TAIL 2'h0
`define ASTP_K_COMMA 8'hBC
`define ASTP_K_R 8'h1C
`define ASTP_K_A 8'h7C
`define ASTP_K_Q 8'h9C
`define ASTP_SCR_SEED 15'h7F80
`define ASTP_PRBS_SEED 15'h7FFF
`define ASTP_CHECK_A 14'h2AAA
`define ASTP_CHECK_B 14'h1555
`endif

// [rtl/astp_packer.sv]
// Transport packer with transport and link test pattern injection.
// How it works
// - Transport patterns replace samples before packing.
// - Link patterns bypass packer, feed encoder input.
// - Register test_pattern_control selects and enables patterns.
// - Link PRBS patterns use standard polynomials.
// - Transport patterns restart on sync release.
// - Three-lane efficient lane rate 140/24.
// - Two-lane efficient lane rate 140/16.
// - Simple mode pads tail, rate times twenty.
// - Efficient frame: four samples, seven octets.
// - Consecutive sample groups go lane by lane.
// - Link parameters stored as value minus one.
// - Simple mode: converter per lane, two octets.
// - Commas during sync, four multiframes alignment.
// - Reset selects efficient packing mode.
// - Alignment sequence seeds the scrambler.
`timescale 1ns/1ps
`include "astp_defs.svh"
module astp_packer (
    input wire logic i_core_clk,                  // Sample clock.
    input wire logic i_rst_n,                     // Synchronous reset, active low.
    input wire logic i_sample_valid,              // New sample(s) this cycle.
    input wire logic [13:0] i_sample_a,           // Converter 0 sample.
    input wire logic [13:0] i_sample_b,           // Converter 1 sample, simple mode.
    input wire logic i_sync_n,                    // Sync request pin, active low.
    input wire logic i_reg_wr,                    // Register write strobe.
    input wire logic i_reg_rd,                    // Register read strobe.
    input wire logic [7:0] i_reg_addr,            // Register address.
    input wire logic [7:0] i_reg_wdata,           // Register write data.
    output logic [7:0] o_reg_rdata,               // Register read data.
    output astp_pkg::astp_octet_t [2:0] o_lane_octet, // Octet per lane to encoder.
    output logic [2:0] o_lane_ctrl,               // Octet is a control character.
    output logic o_lane_valid,                    // Octets valid this cycle.
    output logic [2:0] o_lane_en,                 // Lanes in use.
    output astp_pkg::astp_state_t o_link_state    // Link phase.
);
    import astp_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] tpc;
    logic [7:0] lanes_m1;
    logic [7:0] kfr_m1;
    logic [7:0] mode;
    logic [7:0] next_rdata;
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            tpc <= `ASTP_TPC_RST;
            lanes_m1 <= `ASTP_LANES_RST;
            kfr_m1 <= `ASTP_KFR_RST;
            mode <= `ASTP_MODE_RST;
            o_reg_rdata <= 8'h00;
        end
        else
        begin
            if (i_reg_wr && i_reg_addr == `ASTP_ADDR_TPC) tpc <= i_reg_wdata;
            if (i_reg_wr && i_reg_addr == `ASTP_ADDR_LANES) lanes_m1 <= i_reg_wdata;
            if (i_reg_wr && i_reg_addr == `ASTP_ADDR_KFR) kfr_m1 <= i_reg_wdata;
            if (i_reg_wr && i_reg_addr == `ASTP_ADDR_MODE) mode <= i_reg_wdata;
            if (i_reg_rd) o_reg_rdata <= next_rdata;
        end
    end
    assign next_rdata = (i_reg_addr == `ASTP_ADDR_TPC) ? tpc :
                        (i_reg_addr == `ASTP_ADDR_LANES) ? lanes_m1 :
                        (i_reg_addr == `ASTP_ADDR_KFR) ? kfr_m1 :
                        (i_reg_addr == `ASTP_ADDR_MODE) ? mode :
                        (i_reg_addr == `ASTP_ADDR_STAT) ? {5'h00, o_link_state} : 8'h00;

    // ****************************************
    // Decoded configuration
    // ****************************************
    wire simple = mode[`ASTP_MODE_SIMPLE_BIT];
    wire scr_en = mode[`ASTP_MODE_SCR_BIT];
    // Simple mode always uses two lanes, one per converter.
    wire three_lane = !simple && lanes_m1 == `ASTP_LANES_M1_THREE;
    wire [2:0] f_last = simple ? `ASTP_F_SIMPLE_M1 : `ASTP_F_EFF_M1;
    wire [4:0] k_min = simple ? `ASTP_K_MIN_SIMPLE_M1 : `ASTP_K_MIN_EFF_M1;
    wire [4:0] k_last = (kfr_m1[4:0] < k_min) ? k_min : kfr_m1[4:0];
    wire tp_on = tpc[`ASTP_TPC_EN_BIT];
    wire [2:0] tp_sel = tpc[`ASTP_TPC_SEL_MSB:0];
    wire tp_ramp = tp_on && tp_sel == TP_RAMP;
    wire tp_check = tp_on && tp_sel == TP_CHECK;
    wire tp_link = tp_on && (tp_sel == TP_PRBS7 || tp_sel == TP_PRBS15);

    // ****************************************
    // Sync request input and link phase
    // ****************************************
    logic sync_m;
    logic sync_s;
    logic sync_q;
    logic rel_pend;
    astp_state_t state;
    astp_state_t next_state;
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            sync_m <= 1'b0;
            sync_s <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            sync_m <= i_sync_n;
            sync_s <= sync_m;
            sync_q <= sync_s;
        end
    end
    wire sync_rise = sync_s && !sync_q;

    // ****************************************
    // Sample collection and transport patterns
    // ****************************************
    logic [13:0] coll [12];
    logic [13:0] coll_b;
    logic [3:0] samp_cnt;
    logic [13:0] ramp;
    logic check_ph;
    logic load_q;
    // Patterns take the place of samples so they see the same packing.
    wire [13:0] tp_val = tp_ramp ? ramp : (check_ph ? `ASTP_CHECK_B : `ASTP_CHECK_A);
    wire [13:0] src_a = (tp_ramp || tp_check) ? tp_val : i_sample_a;
    wire [13:0] src_b = (tp_ramp || tp_check) ? ~tp_val : i_sample_b;
    wire grp_last = simple || samp_cnt == (three_lane ? `ASTP_GRP3_LAST : `ASTP_GRP2_LAST);
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n || sync_rise)
        begin
            ramp <= 14'h0000;
            check_ph <= 1'b0;
        end
        else if (i_sample_valid)
        begin
            ramp <= ramp + 14'h0001;
            check_ph <= !check_ph;
        end
    end
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            samp_cnt <= 4'h0;
            load_q <= 1'b0;
        end
        else
        begin
            load_q <= i_sample_valid && grp_last;
            if (i_sample_valid) samp_cnt <= grp_last ? 4'h0 : samp_cnt + 4'h1;
        end
    end
    always_ff @(posedge i_core_clk)
    begin
        if (i_sample_valid)
        begin
            coll[samp_cnt] <= src_a;
            coll_b <= src_b;
        end
    end

    // ****************************************
    // Frame slicing and octet timing
    // ****************************************
    logic busy;
    logic [2:0] oct_idx;
    logic [4:0] fr_cnt;
    logic [1:0] mf_cnt;
    wire frame_end = busy && oct_idx == f_last;
    wire mf_end = frame_end && fr_cnt == k_last;
    // One octet per lane per cycle while a frame drains; the sample valid rate sets
    // the lane rate (12 per 7 octets, 8 per 7 octets, or one per 2 octets).
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            busy <= 1'b0;
            oct_idx <= 3'h0;
        end
        else if (load_q)
        begin
            busy <= 1'b1;
            oct_idx <= 3'h0;
        end
        else if (busy)
        begin
            busy <= !frame_end;
            oct_idx <= oct_idx + 3'h1;
        end
    end
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n || (state == ST_COMMA && load_q))
        begin
            fr_cnt <= 5'h00;
            mf_cnt <= 2'h0;
        end
        else if (frame_end)
        begin
            fr_cnt <= mf_end ? 5'h00 : fr_cnt + 5'h01;
            if (mf_end) mf_cnt <= mf_cnt + 2'h1;
        end
    end

    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_COMMA: if (sync_s && rel_pend && load_q) next_state = ST_ILA;
            ST_ILA:
            begin
                if (!sync_s) next_state = ST_COMMA;
                else if (mf_end && mf_cnt == `ASTP_ILA_MF_LAST) next_state = ST_DATA;
            end
            ST_DATA: if (!sync_s) next_state = ST_COMMA;
        endcase
    end
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            state <= ST_COMMA;
            rel_pend <= 1'b0;
        end
        else
        begin
            state <= next_state;
            // Alignment starts on a frame boundary, so a release mid-frame waits.
            rel_pend <= sync_s && (sync_rise || (rel_pend && state == ST_COMMA && !load_q));
        end
    end

    // ****************************************
    // Link pattern generator
    // ****************************************
    astp_prbs_if prbs ();
    assign prbs.restart = !tp_link;
    // Step only as octets leave, so the stream runs on unbroken from frame to frame.
    // The first octet after a restart is the cleared value, not a pattern octet.
    assign prbs.step = busy;
    assign prbs.long_poly = tp_sel == TP_PRBS15;
    astp_prbs u_prbs (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .bus(prbs.gen)
    );

    // ****************************************
    // Per-lane packing, scrambling and encoder feed
    // ****************************************
    wire ila_r = oct_idx == 3'h0 && fr_cnt == 5'h00;
    wire ila_a = oct_idx == f_last && fr_cnt == k_last;
    wire ila_q = oct_idx == 3'h1 && fr_cnt == 5'h00 && mf_cnt == 2'h1;
    wire [7:0] ila_data = {mf_cnt, fr_cnt[2:0], oct_idx};
    wire ila_ctrl = ila_r || ila_a || ila_q;
    wire [7:0] ila_char = ila_r ? `ASTP_K_R : (ila_a ? `ASTP_K_A : `ASTP_K_Q);

    function automatic logic [22:0] scr_step(input logic [14:0] st, input logic [7:0] din);
        logic [14:0] s;
        logic [7:0] q;
        s = st;
        q = 8'h00;
        for (int i = 7; i >= 0; i--)
        begin
            q[i] = din[i] ^ s[14] ^ s[13];
            s = {s[13:0], q[i]};
        end
        return {s, q};
    endfunction

    for (genvar l = 0; l < 3; l++)
    begin : g_lane
        logic [55:0] sh;
        logic [14:0] scr;
        wire [55:0] eff = {coll[4 * l], coll[4 * l + 1], coll[4 * l + 2], coll[4 * l + 3]};
        wire [55:0] smp = (l == 0) ? {coll[0], `ASTP_TAIL, 40'h0} :
                          (l == 1) ? {coll_b, `ASTP_TAIL, 40'h0} : 56'h0;
        wire [55:0] frame = simple ? smp : eff;
        wire [7:0] pay = sh[55:48];
        wire [22:0] scr_d = scr_step(scr, pay);
        wire [22:0] scr_i = scr_step(scr, ila_data);
        wire lane_on = (l < 2) || three_lane;
        wire [7:0] next_oct = (state == ST_COMMA) ? `ASTP_K_COMMA :
                              (state == ST_ILA) ? (ila_ctrl ? ila_char : ila_data) :
                              tp_link ? prbs.octet :
                              scr_en ? scr_d[7:0] : pay;
        wire next_ctrl = state == ST_COMMA || (state == ST_ILA && ila_ctrl);
        always_ff @(posedge i_core_clk)
        begin
            if (load_q) sh <= frame;
            else if (busy) sh <= {sh[47:0], 8'h00};
        end
        always_ff @(posedge i_core_clk)
        begin
            if (!i_rst_n || state == ST_COMMA) scr <= `ASTP_SCR_SEED;
            else if (busy && state == ST_ILA && !ila_ctrl) scr <= scr_i[22:8];
            else if (busy && state == ST_DATA && !tp_link && scr_en) scr <= scr_d[22:8];
        end
        always_ff @(posedge i_core_clk)
        begin
            if (!i_rst_n)
            begin
                o_lane_octet[l] <= 8'h00;
                o_lane_ctrl[l] <= 1'b0;
                o_lane_en[l] <= 1'b0;
            end
            else
            begin
                o_lane_octet[l] <= (busy && lane_on) ? next_oct : 8'h00;
                o_lane_ctrl[l] <= busy && lane_on && next_ctrl;
                o_lane_en[l] <= lane_on;
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            o_lane_valid <= 1'b0;
            o_link_state <= ST_COMMA;
        end
        else
        begin
            o_lane_valid <= busy;
            o_link_state <= state;
        end
    end
endmodule

// [rtl/astp_pkg.sv]
// Types shared by the transport packer modules.
package astp_pkg;
    typedef enum logic [2:0] {
        ST_COMMA = 3'h1,
        ST_ILA = 3'h2,
        ST_DATA = 3'h4
    } astp_state_t;
    typedef enum logic [2:0] {
        TP_OFF = 3'h0,
        TP_RAMP = 3'h1,
        TP_CHECK = 3'h2,
        TP_PRBS7 = 3'h3,
        TP_PRBS15 = 3'h4
    } astp_tp_sel_t;
    typedef logic [7:0] astp_octet_t;
endpackage

// [rtl/astp_prbs.sv]
// Standard PRBS7 / PRBS15 octet generator for link-layer test patterns.
`timescale 1ns/1ps
`include "astp_defs.svh"
module astp_prbs (
    input wire logic i_core_clk,  // Sample clock.
    input wire logic i_rst_n,     // Synchronous reset, active low.
    astp_prbs_if.gen bus          // Step and restart in, octet out.
);
    import astp_pkg::*;
    logic [14:0] lfsr;
    logic [14:0] next_lfsr;
    logic [7:0] next_octet;

    // Eight serial steps per octet, first bit into the octet MSB.
    always_comb
    begin
        logic fb;
        fb = 1'b0;
        next_lfsr = lfsr;
        next_octet = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            fb = bus.long_poly ? (next_lfsr[14] ^ next_lfsr[13]) : (next_lfsr[6] ^ next_lfsr[5]);
            next_octet[7 - i] = fb;
            next_lfsr = {next_lfsr[13:0], fb};
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n || bus.restart)
        begin
            lfsr <= `ASTP_PRBS_SEED;
            bus.octet <= 8'h00;
        end
        else if (bus.step)
        begin
            lfsr <= next_lfsr;
            bus.octet <= next_octet;
        end
    end
endmodule

// [rtl/astp_prbs_if.sv]
// Connection between the packer and its link-layer pattern generator.
`timescale 1ns/1ps
interface astp_prbs_if;
    logic restart;
    logic step;
    logic long_poly;
    logic [7:0] octet;
    modport gen (input restart, input step, input long_poly, output octet);
    modport user (output restart, output step, output long_poly, input octet);
endinterface

// [sim/astp_packer_properties.sv]
// Concurrent checks on the transport packer's top-level ports.
`timescale 1ns/1ps
`include "astp_defs.svh"
module astp_packer_properties (
    input wire logic i_core_clk,                 // Sample clock.
    input wire logic i_rst_n,                    // Synchronous reset, active low.
    input wire logic i_sample_valid,             // Sample strobe.
    input wire logic [13:0] i_sample_a,          // Converter 0 sample.
    input wire logic [13:0] i_sample_b,          // Converter 1 sample.
    input wire logic i_sync_n,                   // Sync request, active low.
    input wire logic i_reg_wr,                   // Register write strobe.
    input wire logic i_reg_rd,                   // Register read strobe.
    input wire logic [7:0] i_reg_addr,           // Register address.
    input wire logic [7:0] i_reg_wdata,          // Register write data.
    input wire logic [7:0] o_reg_rdata,          // Register read data.
    input astp_pkg::astp_octet_t [2:0] o_lane_octet, // Lane octets.
    input wire logic [2:0] o_lane_ctrl,          // Control character flags.
    input wire logic o_lane_valid,               // Octets valid.
    input wire logic [2:0] o_lane_en,            // Lanes in use.
    input astp_pkg::astp_state_t o_link_state    // Link phase.
);
    import astp_pkg::*;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // ****************************************
    // Sequences
    // ****************************************
    // Two synchroniser flops, the state register and the output register give four edges.
    sequence s_sync_low;
        !i_sync_n [*5];
    endsequence
    sequence s_burst;
        o_lane_valid [*2] ##[1:6] !o_lane_valid;
    endsequence
    // ****************************************
    // Assertions
    // ****************************************
    a_sync_forces_comma: assert property (s_sync_low |-> o_link_state == ST_COMMA)
        else $error("sync held low but link not in comma phase");
    a_comma_octets: assert property (
        o_link_state == ST_COMMA && $past(o_link_state) == ST_COMMA && o_lane_en[0] && o_lane_valid
        && $past(o_lane_en[0]) |-> o_lane_octet[0] == `ASTP_K_COMMA && o_lane_ctrl[0])
        else $error("comma phase lane 0 not sending comma characters");
    a_comma_to_align: assert property (
        $past(o_link_state) == ST_COMMA && o_link_state != ST_COMMA |-> o_link_state == ST_ILA)
        else $error("link left comma phase without alignment");
    a_state_onehot: assert property ($onehot(o_link_state))
        else $error("link state not one-hot");
    a_frame_length: assert property ($rose(o_lane_valid) |-> s_burst)
        else $error("frame length outside two to seven octets");
    a_unused_lane: assert property (
        !o_lane_en[2] |-> o_lane_octet[2] == 8'h00 && !o_lane_ctrl[2])
        else $error("unused lane not quiet");
    a_data_no_ctrl: assert property (
        o_link_state == ST_DATA && $past(o_link_state) == ST_DATA |-> o_lane_ctrl == 3'h0)
        else $error("control character during data phase");
    a_rdata_holds: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
        else $error("read data changed without a read");
    a_status_read: assert property (
        i_reg_rd && i_reg_addr == `ASTP_ADDR_STAT |=> o_reg_rdata == {5'h00, $past(o_link_state)})
        else $error("status read does not show link state");
    a_unmapped_zero: assert property (
        i_reg_rd && (i_reg_addr < 8'hC0 || i_reg_addr > 8'hC4) |=> o_reg_rdata == 8'h00)
        else $error("unmapped register read not zero");
endmodule

// [sim/astp_rx_model.sv]
// Receiver model: holds the sync request until it has seen commas on lane 0.
`timescale 1ns/1ps
`include "astp_defs.svh"
module astp_rx_model (
    input wire logic i_core_clk,          // Sample clock.
    input wire logic i_rst_n,             // Reset, active low.
    input wire logic i_hold,              // Bench keeps sync asserted.
    input astp_pkg::astp_octet_t i_octet, // Lane 0 octet.
    input wire logic i_ctrl,              // Lane 0 control flag.
    output logic o_sync_n                 // Sync request, active low.
);
    import astp_pkg::*;
    logic [2:0] comma_cnt = 3'h0;
    // Four commas, counted without needing to be in a row, stand for code group lock; release then stays.
    always @(negedge i_core_clk)
    begin
        if (!i_rst_n || i_hold)
            comma_cnt <= 3'h0;
        else if (comma_cnt < 3'h4 && i_octet == `ASTP_K_COMMA && i_ctrl)
            comma_cnt <= comma_cnt + 3'h1;
    end
    assign o_sync_n = (comma_cnt == 3'h4);
endmodule

// [sim/tb.sv]
// Self-checking bench for the transport packer.
`timescale 1ns/1ps
`include "astp_defs.svh"
module tb;
    import astp_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_sample_valid = 1'b0;
    logic [13:0] i_sample_a = 14'h2D4B;
    logic [13:0] i_sample_b = 14'h0C35;
    logic i_sync_n;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic [7:0] o_reg_rdata;
    astp_octet_t [2:0] o_lane_octet;
    logic [2:0] o_lane_ctrl;
    logic o_lane_valid;
    logic [2:0] o_lane_en;
    astp_state_t o_link_state;
    logic hold = 1'b1;
    int gap = 1;
    int gap_cnt = 0;
    int miscompares = 0;
    int comparisons = 0;
    astp_packer DUT (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_sample_valid(i_sample_valid),
        .i_sample_a(i_sample_a), .i_sample_b(i_sample_b), .i_sync_n(i_sync_n),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_lane_octet(o_lane_octet),
        .o_lane_ctrl(o_lane_ctrl), .o_lane_valid(o_lane_valid), .o_lane_en(o_lane_en),
        .o_link_state(o_link_state));
    astp_rx_model u_rx (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_hold(hold),
        .i_octet(o_lane_octet[0]), .i_ctrl(o_lane_ctrl[0]), .o_sync_n(i_sync_n));
    initial
    begin
        forever #12.5 i_core_clk = ~i_core_clk;
    end
    // Sample feeder; the gap keeps group ends at least F+1 cycles apart.
    always @(negedge i_core_clk)
    begin
        i_sample_valid <= i_rst_n && gap_cnt == 0;
        gap_cnt <= (gap_cnt >= gap - 1) ? 0 : gap_cnt + 1;
    end
    task automatic chk(input string nm, input logic [55:0] e, input logic [55:0] g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
        @(negedge i_core_clk);
        i_reg_wr = 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_core_clk);
        {i_reg_rd, i_reg_addr} = {1'b1, a};
        @(negedge i_core_clk);
        i_reg_rd = 1'b0;
        @(negedge i_core_clk);
        d = o_reg_rdata;
    endtask
    // Collects one whole frame; the first frame after a change is dropped.
    task automatic grab(input int f, output logic [55:0] l0, output logic [55:0] l1);
        int n;
        for (int k = 0; k < 2; k++)
        begin
            {l0, l1} = '0;
            for (n = 0; n < 100 && o_lane_valid !== 1'b0; n++) @(negedge i_core_clk);
            for (n = 0; n < 100 && o_lane_valid !== 1'b1; n++) @(negedge i_core_clk);
            for (n = 0; n < f; n++)
            begin
                l0 = {l0[47:0], o_lane_octet[0]};
                l1 = {l1[47:0], o_lane_octet[1]};
                @(negedge i_core_clk);
            end
        end
    endtask
    task automatic t_regs;
        logic [7:0] d;
        logic [7:0] exp [5] = '{8'h00, 8'h02, 8'h08, 8'h00, 8'h01};
        for (int i = 0; i < 5; i++)
        begin
            reg_rd(8'hC0 + i[7:0], d);
            chk("reset register", exp[i], d);
        end
        reg_wr(8'hC5, 8'h5A);
        reg_rd(8'hC5, d);
        chk("unmapped read", 8'h00, d);
        reg_wr(8'hC4, 8'hFF);
        reg_rd(8'hC4, d);
        chk("read-only status", 8'h01, d);
        $display("TEST registers done");
    endtask
    task automatic t_link;
        int n;
        for (n = 0; n < 100 && o_lane_valid !== 1'b1; n++) @(negedge i_core_clk);
        chk("comma octet", {1'b1, `ASTP_K_COMMA}, {o_lane_ctrl[0], o_lane_octet[0]});
        hold = 1'b0;
        for (n = 0; n < 100 && o_link_state !== ST_ILA; n++) @(negedge i_core_clk);
        chk("alignment phase", ST_ILA, o_link_state);
        for (n = 0; n < 3000 && o_link_state !== ST_DATA; n++) @(negedge i_core_clk);
        chk("data phase", ST_DATA, o_link_state);
        $display("TEST link done");
    endtask
    task automatic t_pack(input logic [7:0] lanes_m1, input logic [2:0] en);
        logic [55:0] l0;
        logic [55:0] l1;
        reg_wr(8'hC1, lanes_m1);
        grab(7, l0, l1);
        chk("lane enables", en, o_lane_en);
        chk("lane 0 frame", {4{i_sample_a}}, l0);
        chk("lane 1 frame", {4{i_sample_a}}, l1);
        $display("TEST packing done");
    endtask
    task automatic t_patterns;
        logic [55:0] l0;
        logic [55:0] l1;
        logic bad;
        reg_wr(8'hC0, 8'h81);
        grab(7, l0, l1);
        bad = l1[55:42] !== l0[55:42] + 14'h0004;
        for (int j = 0; j < 3; j++)
            bad |= l0[41 - 14 * j -: 14] !== l0[55 - 14 * j -: 14] + 14'h0001;
        chk("ramp pattern", 1'b0, bad);
        reg_wr(8'hC0, 8'h82);
        grab(7, l0, l1);
        bad = (l0 !== {2{`ASTP_CHECK_A, `ASTP_CHECK_B}});
        bad &= (l0 !== {2{`ASTP_CHECK_B, `ASTP_CHECK_A}});
        bad |= l1 !== l0;
        chk("checker pattern", 1'b0, bad);
        for (int p = 0; p < 2; p++)
        begin
            reg_wr(8'hC0, p ? 8'h84 : 8'h83);
            grab(7, l0, l1);
            bad = 1'b0;
            for (int i = 15; i < 56; i++)
                bad |= l0[55-i] !== (p ? l0[69-i] ^ l0[70-i] : l0[61-i] ^ l0[62-i]);
            chk("prbs sequence", 1'b0, bad);
            chk("prbs ctrl", 3'h0, o_lane_ctrl);
        end
        reg_wr(8'hC0, 8'h00);
        reg_wr(8'hC3, 8'h02);
        grab(7, l0, l1);
        bad = 1'b0;
        for (int i = 15; i < 56; i++)
            bad |= (l0[55-i] ^ l0[69-i] ^ l0[70-i]) !== i_sample_a[13 - i % 14];
        chk("scrambled data", 1'b0, bad);
        reg_wr(8'hC3, 8'h00);
        $display("TEST patterns done");
    endtask
    task automatic t_simple;
        logic [55:0] l0;
        logic [55:0] l1;
        // Switch modes between frames so no frame is cut or stretched.
        gap = 3;
        grab(7, l0, l1);
        reg_wr(8'hC3, 8'h01);
        grab(2, l0, l1);
        chk("simple lane 0", {i_sample_a, `ASTP_TAIL}, l0);
        chk("simple lane 1", {i_sample_b, `ASTP_TAIL}, l1);
        chk("simple enables", 3'h3, o_lane_en);
        $display("TEST simple done");
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #(25 * 20000);
        miscompares++;
        print_verdict();
    end
    initial
    begin
        repeat (4) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        t_regs();
        t_link();
        t_pack(8'h02, 3'h7);
        t_pack(8'h01, 3'h3);
        t_patterns();
        t_simple();
        print_verdict();
    end
endmodule
bind astp_packer astp_packer_properties u_props (.*);
